// ==== logic/rstwk_pkg.sv ====
// Constants, register map and carrier types of the reset and wake-up control block.
// Summary of operation
// - Pull reset line while internal cause present
// - Keep sampling the shared reset line
// - Hold line low a stretch after cause
// - Reset mode clears registers except two
// - Flag power-up on low supply or powerup
// - Core supply low raises reset cause
// - I/O supply low raises reset cause
// - Sleep wake-up goes to reset, flagged
// - Filtered external low is reset, also Stop
// - Watchdog misuse raises watchdog reset
// - Eight-bit cause register, six flags, two zeros
// - Reading cause register clears; writes ignored
// - Hide low-voltage flags if power-up/wake set
// - Stop wake-up: interrupt host, go Normal
// - Sleep wake-up: Reset mode, no interrupt
// - Stop command blocked until source read
// - Enabled input level change wakes device
// - Wake-selected inputs lose analog path in Stop/Sleep
// - Input change and forced wake coexist
// - Host Normal request leaves Stop, no flag
// - Stop: core low or external gives Reset
// - Six wake enables, all reset to one
package rstwk_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int HV_N = 6;
	localparam int CNT_W = 16;

	localparam logic [ADDR_W-1:0] OFS_MODE_CTRL = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_WAKE_CTRL = 8'h12;
	localparam logic [ADDR_W-1:0] OFS_WAKE_SRC = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE = 8'h15;

	localparam logic [DATA_W-1:0] WAKE_CTRL_RST = 8'h3f;
	localparam logic [DATA_W-1:0] WAKE_SRC_RST = 8'h00;
	localparam logic [5:0] CAUSE_RST = 6'h01;

	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_STOP = 2'h1;
	localparam logic [1:0] MODE_SLEEP = 2'h2;

	localparam int WSRC_FORCED_BIT = 6;
	localparam int WSRC_LIN_BIT = 7;

	localparam int CLK_PERIOD_NS = 10;
	localparam int RST_STRETCH_NS = 1000;
	localparam int RST_FILTER_NS = 500;
	localparam logic [CNT_W-1:0] STRETCH_CYC =
		CNT_W'((RST_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] FILTER_CYC =
		CNT_W'((RST_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [1:0] {
		st_reset,
		st_normal,
		st_stop,
		st_sleep
	} mode_e;

	typedef struct packed {
		logic watchdog_fault_cause;
		logic external_pin_cause;
		logic sleep_wake_cause;
		logic io_supply_low_cause;
		logic core_supply_low_cause;
		logic power_up_cause;
	} cause_s;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_s;
endpackage : rstwk_pkg

// ==== logic/level_sync.sv ====
// Two-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/1ps
module level_sync #(
	parameter int W = 1
) (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = i_async;
		sync_d = meta_q;
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else if (i_clk_en) begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign o_sync = sync_q;
endmodule : level_sync

// ==== logic/hold_counter.sv ====
// Reports that a level has stood high for a given number of consecutive cycles.
`timescale 1ns/1ps
module hold_counter (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	input wire logic [rstwk_pkg::CNT_W-1:0] i_limit,
	input wire logic i_level,
	output logic o_done
);
	logic [rstwk_pkg::CNT_W-1:0] cnt_q;
	logic [rstwk_pkg::CNT_W-1:0] cnt_d;

	always_comb begin
		if (!i_level) begin
			cnt_d = '0;
		end else if (cnt_q < i_limit) begin
			cnt_d = cnt_q + 1'b1;
		end else begin
			cnt_d = cnt_q;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			cnt_q <= '0;
		end else if (i_clk_en) begin
			cnt_q <= cnt_d;
		end
	end

	assign o_done = i_level && (cnt_q >= i_limit);
endmodule : hold_counter

// ==== logic/reset_and_wakeup_control.sv ====
// Reset line driver, reset cause recording and wake-up mode control.
`timescale 1ns/1ps
module reset_and_wakeup_control (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	input wire rstwk_pkg::reg_req_s i_reg_req,
	output logic [rstwk_pkg::DATA_W-1:0] o_reg_rdata,
	input wire logic i_reset_line_in,
	output logic o_reset_line_out,
	output logic o_reset_line_oe,
	input wire logic i_power_on_low,
	input wire logic i_core_supply_low,
	input wire logic i_io_supply_low,
	input wire logic i_watchdog_fault,
	input wire logic [rstwk_pkg::HV_N-1:0] i_hv_wake_input,
	input wire logic i_forced_wake,
	input wire logic i_lin_wake,
	output logic o_die_link_interrupt,
	output logic [1:0] o_mode,
	output logic o_regs_init,
	output logic [rstwk_pkg::HV_N-1:0] o_analog_path_off
);
	// Seven single-bit levels plus the wake inputs share one synchroniser.
	localparam int SW = rstwk_pkg::HV_N + 7;

	logic [SW-1:0] sync_bus;
	logic pin_s;
	logic por_s;
	logic core_low_s;
	logic io_low_s;
	logic wdog_s;
	logic forced_s;
	logic lin_s;
	logic [rstwk_pkg::HV_N-1:0] hv_s;

	rstwk_pkg::mode_e state_q;
	rstwk_pkg::mode_e state_d;
	rstwk_pkg::cause_s cause_q;
	rstwk_pkg::cause_s cause_d;
	rstwk_pkg::cause_s cause_set;
	rstwk_pkg::cause_s cause_view;
	logic [rstwk_pkg::DATA_W-1:0] wake_ctrl_q;
	logic [rstwk_pkg::DATA_W-1:0] wake_ctrl_d;
	logic [rstwk_pkg::DATA_W-1:0] wake_src_q;
	logic [rstwk_pkg::DATA_W-1:0] wake_src_d;
	logic [rstwk_pkg::DATA_W-1:0] wake_src_set;
	logic [rstwk_pkg::HV_N-1:0] hv_ref_q;
	logic [rstwk_pkg::HV_N-1:0] hv_ref_d;
	logic [rstwk_pkg::HV_N-1:0] hv_change;
	logic src_unread_q;
	logic src_unread_d;
	logic irq_q;
	logic irq_d;
	logic drive_q;
	logic drive_d;
	logic hold_req_q;
	logic hold_req_d;
	logic [rstwk_pkg::DATA_W-1:0] rdata_q;
	logic [rstwk_pkg::DATA_W-1:0] rdata_d;
	logic regs_init_q;
	logic regs_init_d;
	logic line_out_q;
	logic line_out_d;
	logic [1:0] mode_out_q;
	logic [1:0] mode_out_d;
	logic [rstwk_pkg::HV_N-1:0] analog_off_q;
	logic [rstwk_pkg::HV_N-1:0] analog_off_d;

	logic internal_cause;
	logic ext_reset;
	logic stretch_done;
	logic low_power;
	logic wake_any;
	logic rd_cause;
	logic rd_src;
	logic wr_mode;
	logic wr_wake_ctrl;
	logic [1:0] req_mode;

	// Every pin and analog comparator output is asynchronous to the base clock.
	// The synchroniser resets low; our own drive hides that false pin low after reset.
	level_sync #(
		.W(SW)
	) u_sync (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_clk_en(i_clk_en),
		.i_async({i_reset_line_in, i_power_on_low, i_core_supply_low, i_io_supply_low,
			i_watchdog_fault, i_forced_wake, i_lin_wake, i_hv_wake_input}),
		.o_sync(sync_bus)
	);

	assign {pin_s, por_s, core_low_s, io_low_s, wdog_s, forced_s, lin_s, hv_s} = sync_bus;

	// Filtered pin low
	// Our own drive is excluded so the device never reports itself as external.
	hold_counter u_pin_filter (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_clk_en(i_clk_en),
		.i_limit(rstwk_pkg::FILTER_CYC),
		.i_level(!pin_s && !drive_q),
		.o_done(ext_reset)
	);

	// Release stretch timer
	// It restarts while any hold request stands, so the stretch runs from the last cause.
	hold_counter u_stretch (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_clk_en(i_clk_en),
		.i_limit(rstwk_pkg::STRETCH_CYC),
		.i_level(!hold_req_q),
		.o_done(stretch_done)
	);

	// Register access decode.
	// Writes to the status offsets decode to nothing.
	always_comb begin
		rd_cause = 1'b0;
		rd_src = 1'b0;
		wr_mode = 1'b0;
		wr_wake_ctrl = 1'b0;
		if (i_reg_req.addr == rstwk_pkg::OFS_RESET_CAUSE) begin
			rd_cause = i_reg_req.rd;
		end else if (i_reg_req.addr == rstwk_pkg::OFS_WAKE_SRC) begin
			rd_src = i_reg_req.rd;
		end else if (i_reg_req.addr == rstwk_pkg::OFS_MODE_CTRL) begin
			wr_mode = i_reg_req.wr;
		end else if (i_reg_req.addr == rstwk_pkg::OFS_WAKE_CTRL) begin
			wr_wake_ctrl = i_reg_req.wr;
		end
	end

	assign req_mode = i_reg_req.wdata[1:0];
	// Wake events are only looked at while in a low-power mode.
	assign low_power = (state_q == rstwk_pkg::st_stop) || (state_q == rstwk_pkg::st_sleep);

	// Wake event sources
	// Forced, input-change and bus wakes are simply OR-ed, so any one ends low power.
	always_comb begin
		hv_change = (hv_s ^ hv_ref_q) & wake_ctrl_q[rstwk_pkg::HV_N-1:0];
		wake_src_set = '0;
		if (low_power) begin
			wake_src_set[rstwk_pkg::HV_N-1:0] = hv_change;
			wake_src_set[rstwk_pkg::WSRC_FORCED_BIT] = forced_s;
			wake_src_set[rstwk_pkg::WSRC_LIN_BIT] = lin_s;
		end
		wake_any = |wake_src_set;
	end

	always_comb begin
		cause_set = '0;
		// The system reset value of the register carries the power-up flag as well.
		cause_set.power_up_cause = por_s;
		cause_set.core_supply_low_cause = core_low_s;
		cause_set.io_supply_low_cause = io_low_s;
		cause_set.watchdog_fault_cause = wdog_s;
		cause_set.external_pin_cause = ext_reset;
		cause_set.sleep_wake_cause = (state_q == rstwk_pkg::st_sleep) && wake_any;
		internal_cause = por_s || core_low_s || io_low_s || wdog_s;
	end

	// Mode state machine.
	always_comb begin
		state_d = state_q;
		// The clear by a source read comes first, so a wake in the same cycle still sets.
		irq_d = irq_q && !rd_src;
		// Mode writes are taken in Normal and Stop only; Sleep ends by a wake or a reset cause.
		case (state_q)
			rstwk_pkg::st_reset: begin
				if (stretch_done && !ext_reset) begin
					state_d = rstwk_pkg::st_normal;
				end
			end
			rstwk_pkg::st_normal: begin
				// A mode value of three is not a mode and is ignored.
				// Stop blocked until read
				if (wr_mode && req_mode == rstwk_pkg::MODE_STOP && !src_unread_q) begin
					state_d = rstwk_pkg::st_stop;
				end else if (wr_mode && req_mode == rstwk_pkg::MODE_SLEEP) begin
					state_d = rstwk_pkg::st_sleep;
				end
			end
			rstwk_pkg::st_stop: begin
				if (wake_any) begin
					state_d = rstwk_pkg::st_normal;
					irq_d = 1'b1;
				end else if (wr_mode && req_mode == rstwk_pkg::MODE_NORMAL) begin
					state_d = rstwk_pkg::st_normal;
				end
			end
			rstwk_pkg::st_sleep: begin
				// Sleep has no interrupt path; the cause flag tells the host why it restarted.
				if (wake_any) begin
					state_d = rstwk_pkg::st_reset;
				end
			end
			default: begin
				state_d = rstwk_pkg::st_reset;
			end
		endcase
		if (internal_cause || ext_reset) begin
			state_d = rstwk_pkg::st_reset;
		end
		// No interrupt in reset
		// Reset mode puts the interrupt back to its default, whatever sent us there.
		if (state_d == rstwk_pkg::st_reset) begin
			irq_d = 1'b0;
		end
	end

	// Line drive follows the cause, then the stretch timer.
	// While the pin is held from outside and no internal cause stands, we let go, so the stretch starts at its release.
	always_comb begin
		hold_req_d = internal_cause || ext_reset ||
			(state_d == rstwk_pkg::st_reset && state_q != rstwk_pkg::st_reset);
		drive_d = internal_cause || (state_d == rstwk_pkg::st_reset && !ext_reset &&
			(hold_req_d || !stretch_done));
	end

	// Register file next values.
	always_comb begin
		wake_ctrl_d = wake_ctrl_q;
		hv_ref_d = hv_ref_q;
		// The two upper enable bits are stored only; cyclic sensing is not built here.
		if (wr_wake_ctrl) begin
			wake_ctrl_d = i_reg_req.wdata;
		end
		// Reference levels are taken at entry so that only later changes wake.
		if (!low_power) begin
			hv_ref_d = hv_s;
		end
		if (state_d == rstwk_pkg::st_reset) begin
			wake_ctrl_d = rstwk_pkg::WAKE_CTRL_RST;
		end
		// Sticky, read clears
		// A cause arriving during the clearing read is kept.
		cause_d = rd_cause ? cause_set : (cause_q | cause_set);
		wake_src_d = rd_src ? wake_src_set : (wake_src_q | wake_src_set);
		// Pending source read
		// Sleep wakes count too: after the restart the source still has to be read.
		src_unread_d = (src_unread_q && !rd_src) || wake_any;
	end

	always_comb begin
		cause_view = cause_q;
		if (cause_q.power_up_cause || cause_q.sleep_wake_cause) begin
			cause_view.core_supply_low_cause = 1'b0;
			cause_view.io_supply_low_cause = 1'b0;
		end
	end

	always_comb begin
		rdata_d = rdata_q;
		if (i_reg_req.rd) begin
			if (i_reg_req.addr == rstwk_pkg::OFS_RESET_CAUSE) begin
				rdata_d = {2'h0, cause_view};
			end else if (i_reg_req.addr == rstwk_pkg::OFS_WAKE_SRC) begin
				rdata_d = wake_src_q;
			end else if (i_reg_req.addr == rstwk_pkg::OFS_WAKE_CTRL) begin
				rdata_d = wake_ctrl_q;
			end else if (i_reg_req.addr == rstwk_pkg::OFS_MODE_CTRL) begin
				rdata_d = {6'h00, mode_out_q};
			end else begin
				// Unmapped offsets read as zero rather than the last value.
				rdata_d = 8'h00;
			end
		end
	end

	// Outputs toward the rest of the die.
	// Every one of them is registered, so the far side never sees decode glitches.
	always_comb begin
		regs_init_d = (state_d == rstwk_pkg::st_reset);
		// Open-drain data stays low
		// Only the enable moves; the host's pull-up gives the released level.
		line_out_d = 1'b0;
		case (state_d)
			rstwk_pkg::st_stop: mode_out_d = rstwk_pkg::MODE_STOP;
			rstwk_pkg::st_sleep: mode_out_d = rstwk_pkg::MODE_SLEEP;
			default: mode_out_d = rstwk_pkg::MODE_NORMAL;
		endcase
		if (state_d == rstwk_pkg::st_stop || state_d == rstwk_pkg::st_sleep) begin
			analog_off_d = wake_ctrl_q[rstwk_pkg::HV_N-1:0];
		end else begin
			analog_off_d = '0;
		end
	end

	// Synchronous reset; a low clock enable freezes every register here and in the timers.
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			state_q <= rstwk_pkg::st_reset;
			cause_q <= rstwk_pkg::CAUSE_RST;
			wake_ctrl_q <= rstwk_pkg::WAKE_CTRL_RST;
			wake_src_q <= rstwk_pkg::WAKE_SRC_RST;
			hv_ref_q <= '0;
			src_unread_q <= 1'b0;
			irq_q <= 1'b0;
			drive_q <= 1'b1;
			hold_req_q <= 1'b1;
			rdata_q <= 8'h00;
			regs_init_q <= 1'b1;
			line_out_q <= 1'b0;
			mode_out_q <= rstwk_pkg::MODE_NORMAL;
			analog_off_q <= '0;
		end else if (i_clk_en) begin
			state_q <= state_d;
			cause_q <= cause_d;
			wake_ctrl_q <= wake_ctrl_d;
			wake_src_q <= wake_src_d;
			hv_ref_q <= hv_ref_d;
			src_unread_q <= src_unread_d;
			irq_q <= irq_d;
			drive_q <= drive_d;
			hold_req_q <= hold_req_d;
			rdata_q <= rdata_d;
			regs_init_q <= regs_init_d;
			line_out_q <= line_out_d;
			mode_out_q <= mode_out_d;
			analog_off_q <= analog_off_d;
		end
	end

	assign o_reg_rdata = rdata_q;
	assign o_reset_line_out = line_out_q;
	assign o_reset_line_oe = drive_q;
	assign o_die_link_interrupt = irq_q;
	assign o_mode = mode_out_q;
	assign o_regs_init = regs_init_q;
	assign o_analog_path_off = analog_off_q;
endmodule : reset_and_wakeup_control

// ==== bench/reset_and_wakeup_control_assertions.sv ====
// Port-level checker of the reset and wake-up control block.
`timescale 1ns/1ps
module rstwk_checker (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire rstwk_pkg::reg_req_s i_reg_req,
	input wire logic [rstwk_pkg::DATA_W-1:0] o_reg_rdata,
	input wire logic i_reset_line_in,
	input wire logic o_reset_line_out,
	input wire logic o_reset_line_oe,
	input wire logic i_power_on_low,
	input wire logic i_core_supply_low,
	input wire logic i_io_supply_low,
	input wire logic i_watchdog_fault,
	input wire logic i_forced_wake,
	input wire logic o_die_link_interrupt,
	input wire logic [1:0] o_mode,
	input wire logic o_regs_init,
	input wire logic [rstwk_pkg::HV_N-1:0] o_analog_path_off
);
	logic rd_cause_q, rd_cause_d, oe_q, cause_raw;
	logic [7:0] quiet_q, quiet_d;
	assign cause_raw = i_power_on_low | i_core_supply_low | i_io_supply_low | i_watchdog_fault;
	// The quiet count restarts on any cause, so the stretch is measured from the last one.
	always_comb begin
		rd_cause_d = i_reg_req.rd && (i_reg_req.addr == rstwk_pkg::OFS_RESET_CAUSE);
		quiet_d = (quiet_q == 8'hff) ? quiet_q : quiet_q + 8'h01;
		if (i_sys_rst || cause_raw || (!i_reset_line_in && !o_reset_line_oe) ||
			(o_reset_line_oe && !oe_q))
			quiet_d = 8'h00;
	end
	always_ff @(posedge i_clock) begin
		rd_cause_q <= rd_cause_d;
		oe_q <= o_reset_line_oe;
		quiet_q <= quiet_d;
	end
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_sys_rst);
	a_line_out_low: assert property (o_reset_line_out == 1'b0)
		else $error("reset line data not low");
	a_cause_pulls_line: assert property (cause_raw [*3] |-> ##[0:3] o_reset_line_oe)
		else $error("reset line not pulled on cause");
	a_stretch_len: assert property ($fell(o_reset_line_oe) |->
		quiet_q + 8'h01 >= rstwk_pkg::STRETCH_CYC && quiet_q <= rstwk_pkg::STRETCH_CYC + 8'h08)
		else $error("reset stretch length wrong");
	a_rdata_top_zero: assert property (rd_cause_q |-> o_reg_rdata[7:6] == 2'h0)
		else $error("cause upper bits not zero");
	a_lv_masked: assert property (rd_cause_q && (o_reg_rdata[0] || o_reg_rdata[3]) |->
		o_reg_rdata[2:1] == 2'h0)
		else $error("low voltage flags not masked");
	a_stop_wake_irq: assert property ((o_mode == rstwk_pkg::MODE_STOP && i_forced_wake) [*2]
		|-> ##[0:5] (o_die_link_interrupt && o_mode == rstwk_pkg::MODE_NORMAL))
		else $error("stop wake without interrupt");
	a_sleep_wake_reset: assert property ((o_mode == rstwk_pkg::MODE_SLEEP && i_forced_wake) [*2]
		|-> ##[0:5] (o_regs_init && !o_die_link_interrupt))
		else $error("sleep wake did not reset");
	a_normal_request: assert property (o_mode == rstwk_pkg::MODE_STOP && i_reg_req.wr &&
		i_reg_req.addr == rstwk_pkg::OFS_MODE_CTRL && i_reg_req.wdata[1:0] == 2'h0 |->
		##[1:2] (o_mode == rstwk_pkg::MODE_NORMAL && !o_die_link_interrupt))
		else $error("normal request did not leave stop");
	a_analog_off: assert property (o_mode == rstwk_pkg::MODE_NORMAL |-> o_analog_path_off == 6'h00)
		else $error("analog path off outside low power");
endmodule : rstwk_checker
bind reset_and_wakeup_control rstwk_checker u_checker (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
	.i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata), .i_reset_line_in(i_reset_line_in),
	.o_reset_line_out(o_reset_line_out), .o_reset_line_oe(o_reset_line_oe),
	.i_power_on_low(i_power_on_low), .i_core_supply_low(i_core_supply_low),
	.i_io_supply_low(i_io_supply_low), .i_watchdog_fault(i_watchdog_fault),
	.i_forced_wake(i_forced_wake), .o_die_link_interrupt(o_die_link_interrupt),
	.o_mode(o_mode), .o_regs_init(o_regs_init), .o_analog_path_off(o_analog_path_off));

// ==== bench/host_model.sv ====
// Host side of the shared open-drain reset line, with its pull-up.
`timescale 1ns/1ps
module host_model (
	input wire logic i_pull,
	input wire logic i_dev_oe,
	input wire logic i_dev_data,
	output logic o_line
);
	// wired line level
	// The pull-up only wins when neither party sinks the line.
	assign o_line = !i_pull && !(i_dev_oe && !i_dev_data);
endmodule : host_model

// ==== bench/reset_and_wakeup_control_bench.sv ====
// Self-checking bench of the reset and wake-up control block.
`timescale 1ns/1ps
module reset_and_wakeup_control_bench;
	logic i_clock = 1'b0, i_sys_rst = 1'b1, host_pull = 1'b0, forced = 1'b0, lin = 1'b0;
	rstwk_pkg::reg_req_s reg_req = '0;
	logic [7:0] o_reg_rdata;
	logic line, oe, dat, irq, regs_init, rd_seen = 1'b0;
	logic [3:0] cause_in = 4'h0;
	logic [5:0] hv = 6'h00, aoff;
	logic [1:0] mode;
	logic [7:0] exp_q[$];
	logic [7:0] tbl_exp [5] = '{8'h02, 8'h04, 8'h20, 8'h01, 8'h01};
	logic [3:0] tbl_src [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h9};
	int mismatches = 0, total_checks = 0, cycles = 0;
	reset_and_wakeup_control DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1),
		.i_reg_req(reg_req), .o_reg_rdata(o_reg_rdata), .i_reset_line_in(line),
		.o_reset_line_out(dat), .o_reset_line_oe(oe), .i_power_on_low(cause_in[3]),
		.i_core_supply_low(cause_in[0]), .i_io_supply_low(cause_in[1]),
		.i_watchdog_fault(cause_in[2]), .i_hv_wake_input(hv), .i_forced_wake(forced),
		.i_lin_wake(lin), .o_die_link_interrupt(irq), .o_mode(mode), .o_regs_init(regs_init),
		.o_analog_path_off(aoff));
	host_model u_host (.i_pull(host_pull), .i_dev_oe(oe), .i_dev_data(dat), .o_line(line));
	always #5 i_clock = ~i_clock;
	task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic results();
		if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : results
	task automatic tick(int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : tick
	task automatic req(logic r, logic w, logic [7:0] a, logic [7:0] d);
		tick(1);
		reg_req = {r, w, a, d};
		tick(1);
		reg_req = '0;
	endtask : req
	task automatic rd(logic [7:0] a, logic [7:0] e);
		exp_q.push_back(e);
		req(1'b1, 1'b0, a, 8'h00);
	endtask : rd
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			results();
		end
	end
	// Read data lands on the edge that takes the read, so it is looked at half a cycle later.
	always @(negedge i_clock) begin
		if (rd_seen) check("rdata", o_reg_rdata, exp_q.pop_front());
		rd_seen = reg_req.rd;
	end
	initial begin
		void'($urandom(32'h33e54926));
		hv = 6'($urandom());
		tick(16);
		check("oe in reset", oe, 1'b1);
		check("init in reset", regs_init, 1'b1);
		i_sys_rst = 1'b0;
		tick(130);
		check("oe after reset", oe, 1'b0);
		rd(rstwk_pkg::OFS_RESET_CAUSE, 8'h01);
		rd(rstwk_pkg::OFS_RESET_CAUSE, 8'h00);
		rd(rstwk_pkg::OFS_WAKE_CTRL, rstwk_pkg::WAKE_CTRL_RST);
		rd(8'h3c, 8'h00);
		req(1'b0, 1'b1, rstwk_pkg::OFS_RESET_CAUSE, 8'($urandom()));
		rd(rstwk_pkg::OFS_RESET_CAUSE, 8'h00);
		for (int i = 0; i < 5; i++) begin
			cause_in = tbl_src[i];
			tick(8);
			check("oe on cause", oe, 1'b1);
			cause_in = 4'h0;
			tick(60);
			check("oe stretch", oe, 1'b1);
			tick(60);
			check("oe released", oe, 1'b0);
			rd(rstwk_pkg::OFS_RESET_CAUSE, tbl_exp[i]);
		end
		req(1'b0, 1'b1, rstwk_pkg::OFS_WAKE_CTRL, 8'h05);
		req(1'b0, 1'b1, rstwk_pkg::OFS_MODE_CTRL, 8'h01);
		tick(3);
		check("analog off", aoff, 6'h05);
		hv[1] = ~hv[1];
		tick(10);
		check("mode", mode, rstwk_pkg::MODE_STOP);
		hv[2] = ~hv[2];
		tick(8);
		check("mode", mode, rstwk_pkg::MODE_NORMAL);
		check("irq", irq, 1'b1);
		req(1'b0, 1'b1, rstwk_pkg::OFS_MODE_CTRL, 8'h01);
		tick(3);
		check("mode", mode, rstwk_pkg::MODE_NORMAL);
		rd(rstwk_pkg::OFS_WAKE_SRC, 8'h04);
		for (int i = 0; i < 3; i++) begin
			// Three idle cycles between the source read and the mode write.
			tick(2);
			check("irq", irq, 1'b0);
			req(1'b0, 1'b1, rstwk_pkg::OFS_MODE_CTRL, 8'h01);
			tick(3);
			check("mode", mode, rstwk_pkg::MODE_STOP);
			if (i == 2) break;
			{lin, forced} = 2'(i + 1);
			tick(6);
			{lin, forced} = 2'h0;
			check("mode", mode, rstwk_pkg::MODE_NORMAL);
			rd(rstwk_pkg::OFS_WAKE_SRC, 8'h40 << i);
		end
		req(1'b0, 1'b1, rstwk_pkg::OFS_MODE_CTRL, 8'h00);
		tick(2);
		check("mode", mode, rstwk_pkg::MODE_NORMAL);
		rd(rstwk_pkg::OFS_WAKE_SRC, 8'h00);
		host_pull = 1'b1;
		tick(30);
		host_pull = 1'b0;
		rd(rstwk_pkg::OFS_RESET_CAUSE, 8'h00);
		req(1'b0, 1'b1, rstwk_pkg::OFS_MODE_CTRL, 8'h01);
		tick(3);
		host_pull = 1'b1;
		tick(60);
		check("init", regs_init, 1'b1);
		tick(10);
		host_pull = 1'b0;
		tick(130);
		rd(rstwk_pkg::OFS_RESET_CAUSE, 8'h10);
		req(1'b0, 1'b1, rstwk_pkg::OFS_WAKE_CTRL, 8'h01);
		req(1'b0, 1'b1, rstwk_pkg::OFS_MODE_CTRL, 8'h02);
		tick(3);
		check("analog off", aoff, 6'h01);
		forced = 1'b1;
		tick(6);
		forced = 1'b0;
		check("init", regs_init, 1'b1);
		check("irq", irq, 1'b0);
		tick(130);
		rd(rstwk_pkg::OFS_RESET_CAUSE, 8'h08);
		rd(rstwk_pkg::OFS_WAKE_SRC, 8'h40);
		rd(rstwk_pkg::OFS_WAKE_CTRL, 8'h3f);
		tick(3);
		results();
	end
endmodule : reset_and_wakeup_control_bench
